// ### fasu_pkg.sv
package fasu_pkg;

	// Timing.
	localparam int CLK_PERIOD_NS = 8;
	localparam int QUAL_TIME_US = 500;
	localparam int QUAL_CYC_DEF = (QUAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLR_TIME_US = 8;
	localparam int CLR_CYC = (CLR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0] CLR_CNT_RST = 10'(CLR_CYC);

	// Register offsets.
	localparam logic [7:0] OFS_SWRST = 8'h01;
	localparam logic [7:0] OFS_STATUS = 8'h0B;
	localparam logic [7:0] OFS_MASK = 8'h0C;
	localparam logic [7:0] OFS_ACTION = 8'h0D;
	localparam logic [7:0] OFS_CODE = 8'h0E;

	// Status and mask field positions.
	localparam int ST_IFLT_LSB = 0;
	localparam int ST_VSHORT_LSB = 4;
	localparam int ST_OTEMP = 8;
	localparam int ST_CRC = 9;
	localparam int ST_WDT = 10;
	localparam int ST_HSMAX = 11;
	localparam int ST_PG_LSB = 12;
	localparam int ST_ALARM_W = 12;

	// Action field positions.
	localparam int ACT_OT_LSB = 0;
	localparam int ACT_OUT_LSB = 2;
	localparam int ACT_COM_LSB = 4;
	localparam int ACT_SATONLY = 6;

	// Reset values.
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [15:0] ACTION_RST = 16'h0000;
	localparam logic [5:0] CODE_RST = 6'h00;

	typedef enum logic [1:0] {
		FASU_ACT_NONE = 2'b00,
		FASU_ACT_CODE = 2'b01,
		FASU_ACT_OFF = 2'b10,
		FASU_ACT_RSVD = 2'b11
	} fasu_act_t;

	// Analog comparator levels, asynchronous to sys_clk.
	typedef struct packed {
		logic [3:0] iout_open;
		logic [3:0] iout_compl;
		logic [3:0] conv_sat;
		logic [3:0] vout_short;
		logic [3:0] conv_at_max;
		logic [3:0] pos_ok;
		logic [3:0] neg_ok;
		logic over_temp;
	} fasu_pins_t;

	// Configuration from the device's own registers, same clock.
	typedef struct packed {
		logic [3:0] iout_en;
		logic [3:0] vout_en;
		logic [3:0] pos_arm_en;
		logic [3:0] neg_arm_en;
		logic [3:0] bb_powered;
		logic wdt_en;
		logic crc_en;
	} fasu_cfg_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic hit;
	} fasu_qual_state_t;

	typedef struct packed {
		fasu_pins_t s1;
		fasu_pins_t s2;
		logic [ST_ALARM_W-1:0] flags;
		logic [15:0] mask;
		logic [15:0] action;
		logic [5:0] code;
		logic [3:0] latch;
		logic [3:0] chan_off;
		logic code_applied;
		logic [9:0] clr_cnt;
		logic alarm_drive;
		logic [15:0] rdata;
		logic rvalid;
	} fasu_state_t;

endpackage

// ### fasu_qual.sv
module fasu_qual
	import fasu_pkg::*;
#(
	parameter logic [15:0] QUAL_CYC = 16'(QUAL_CYC_DEF)
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Condition and qualified result.
	input wire logic cond,
	output logic hit
);

	fasu_qual_state_t q, n;

	// The result rises only after the condition has held for QUAL_CYC cycles.
	always_comb begin
		n = q;
		if (!cond) begin
			n.cnt = 16'h0000;
			n.hit = 1'b0;
		end else if (q.cnt == QUAL_CYC - 16'h0001) begin
			n.hit = 1'b1;
		end else begin
			n.cnt = q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign hit = q.hit;

	property p_qual_drop;
		@(posedge sys_clk) disable iff (!rst_n)
		!cond |=> !hit;
	endproperty
	a_qual_drop: assert property (p_qual_drop) else $error("qualified hit without condition");

	property p_qual_rise;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(hit) |-> $past(cond) && (q.cnt == QUAL_CYC - 16'h0001);
	endproperty
	a_qual_rise: assert property (p_qual_rise) else $error("hit rose before full time");

endmodule // fasu_qual

// ### fasu_top.sv
// Function
// - Open current output held past qualification time raises an alarm.
// - Lost compliance headroom on an enabled current output, qualified, raises an alarm.
// - Over-temperature indication raises an alarm.
// - Enabled watchdog timeout and frame check error each raise an alarm.
// - Voltage output held at short limit past qualification time raises alarm.
// - Converter at its high-side maximum output raises an alarm.
// - Alarm is non-latched by default and releases when no condition remains.
// - Open current fault with converter powering channel latches the alarm low.
// - Latch released by flag clear, software reset, reset pin or power-on.
// - Current fault action 10 shuts the channel off on an open fault; alarm reverts non-latched.
// - Per-converter read-only supply good flag: at least one arm enabled and every enabled arm in range.
// - Alarm event sets a sticky flag, cleared by writing one.
// - Resets clear the flags, taking at least the minimum clear time.
// - A cleared flag sets again next cycle if its condition remains.
// - A set mask bit keeps its condition off the alarm output.
// - Choice of code-load action follows priority: temperature, output, then frame/watchdog.
// - Action 01 loads the six-bit fallback code into the converters.
// - Applied fallback code stays after the condition disappears.
// - Fallback code is applied as a step, bypassing slew stepping.
// - Compliance alarm may be limited to a saturated converter.
// - Power-on reset gives default registers and disabled outputs.
module fasu_top
	import fasu_pkg::*;
#(
	parameter logic [15:0] QUAL_CYC = 16'(QUAL_CYC_DEF)
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_b,
	// Analog fault indications.
	input wire fasu_pins_t pins,
	// Configuration and serial-port events.
	input wire fasu_cfg_t cfg,
	input wire logic wdt_timeout,
	input wire logic crc_error,
	// Register port.
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// Alarm pin, open drain.
	input wire logic alarm_i,
	output logic alarm_o,
	output logic alarm_oe_b,
	// Alarm actions.
	output logic [5:0] fallback_code,
	output logic fallback_apply,
	output logic [3:0] chan_off
);

	logic [1:0] rst_sync_q;
	logic rst_n;
	fasu_state_t q, n;
	fasu_pins_t p;
	logic [3:0] q_open, q_compl, q_short;
	logic [3:0] c_open, c_compl, c_short;
	logic [3:0] pg;
	logic [ST_ALARM_W-1:0] live, w1c;
	logic swrst;
	logic sat_only;
	fasu_act_t act_ot, act_out, act_com, act_sel;

	// Reset is released through two flip-flops.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	assign p = q.s2;
	assign sat_only = q.action[ACT_SATONLY];
	assign act_ot = fasu_act_t'(q.action[ACT_OT_LSB +: 2]);
	assign act_out = fasu_act_t'(q.action[ACT_OUT_LSB +: 2]);
	assign act_com = fasu_act_t'(q.action[ACT_COM_LSB +: 2]);
	assign c_open = p.iout_open & cfg.iout_en;
	assign c_compl = p.iout_compl & cfg.iout_en & ({4{~sat_only}} | p.conv_sat);
	assign c_short = p.vout_short & cfg.vout_en;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			fasu_qual #(.QUAL_CYC(QUAL_CYC)) u_open (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.cond(c_open[g]),
				.hit(q_open[g])
			);
			fasu_qual #(.QUAL_CYC(QUAL_CYC)) u_compl (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.cond(c_compl[g]),
				.hit(q_compl[g])
			);
			fasu_qual #(.QUAL_CYC(QUAL_CYC)) u_short (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.cond(c_short[g]),
				.hit(q_short[g])
			);
			// Good only when every enabled arm is in range and one arm is on.
			assign pg[g] = (cfg.pos_arm_en[g] | cfg.neg_arm_en[g])
				& (~cfg.pos_arm_en[g] | p.pos_ok[g])
				& (~cfg.neg_arm_en[g] | p.neg_ok[g]);
		end
	endgenerate

	always_comb begin
		live = '0;
		live[ST_IFLT_LSB +: 4] = q_open | q_compl;
		live[ST_VSHORT_LSB +: 4] = q_short;
		live[ST_OTEMP] = p.over_temp;
		live[ST_CRC] = cfg.crc_en & crc_error;
		live[ST_WDT] = cfg.wdt_en & wdt_timeout;
		live[ST_HSMAX] = |p.conv_at_max;
	end

	assign swrst = reg_wr && (reg_addr == OFS_SWRST);
	assign w1c = (reg_wr && reg_addr == OFS_STATUS) ? reg_wdata[ST_ALARM_W-1:0] : '0;

	// Highest-priority active group chooses the action.
	always_comb begin
		if (live[ST_OTEMP]) begin
			act_sel = act_ot;
		end else if (|live[ST_VSHORT_LSB +: 4] || |live[ST_IFLT_LSB +: 4]) begin
			act_sel = act_out;
		end else if (q.flags[ST_CRC] || q.flags[ST_WDT]) begin
			act_sel = act_com;
		end else begin
			act_sel = FASU_ACT_NONE;
		end
	end

	always_comb begin
		n = q;
		n.s1 = pins;
		n.s2 = q.s1;
		n.rvalid = reg_rd;
		if (swrst) begin
			n.flags = '0;
			n.mask = MASK_RST;
			n.action = ACTION_RST;
			n.code = CODE_RST;
			n.latch = 4'h0;
			n.chan_off = 4'h0;
			n.code_applied = 1'b0;
			n.clr_cnt = CLR_CNT_RST;
		end else begin
			if (q.clr_cnt != 10'h000) begin
				n.clr_cnt = q.clr_cnt - 10'h001;
				n.flags = '0;
			end else begin
				n.flags = live | (q.flags & ~w1c);
				n.flags[ST_WDT] = n.flags[ST_WDT] & cfg.wdt_en;
			end
			if (reg_wr && reg_addr == OFS_MASK) begin
				n.mask = reg_wdata;
			end
			if (reg_wr && reg_addr == OFS_ACTION) begin
				n.action = reg_wdata;
			end
			if (reg_wr && reg_addr == OFS_CODE) begin
				n.code = reg_wdata[5:0];
			end
			// Latched only while the channel is not being shut off instead.
			n.latch = ((q.latch & ~w1c[ST_IFLT_LSB +: 4])
				| (q_open & cfg.bb_powered & ~q.mask[ST_IFLT_LSB +: 4]))
				& {4{act_out != FASU_ACT_OFF}};
			n.chan_off = q.chan_off & ~w1c[ST_IFLT_LSB +: 4];
			if (act_out == FASU_ACT_OFF) begin
				n.chan_off = n.chan_off | q_open;
			end
			if (act_sel == FASU_ACT_CODE) begin
				n.code_applied = 1'b1;
			end
		end
		n.alarm_drive = |((live | {8'h00, q.latch}) & ~q.mask[ST_ALARM_W-1:0]);
		unique case (reg_addr)
			OFS_STATUS: n.rdata = {pg, q.flags};
			OFS_MASK: n.rdata = q.mask;
			OFS_ACTION: n.rdata = q.action;
			OFS_CODE: n.rdata = {10'h000, q.code};
			default: n.rdata = 16'h0000;
		endcase
		if (!reg_rd) begin
			n.rdata = q.rdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.mask <= MASK_RST;
			q.action <= ACTION_RST;
			q.code <= CODE_RST;
			q.clr_cnt <= CLR_CNT_RST;
		end else begin
			q <= n;
		end
	end

	assign reg_rdata = q.rdata;
	assign reg_rvalid = q.rvalid;
	assign alarm_o = 1'b0;
	assign alarm_oe_b = ~q.alarm_drive;
	assign fallback_code = q.code;
	assign fallback_apply = q.code_applied;
	assign chan_off = q.chan_off;

	property p_swrst_clear;
		@(posedge sys_clk) disable iff (!rst_n)
		swrst |=> (q.flags == '0) && (q.latch == 4'h0) && (q.clr_cnt == CLR_CNT_RST);
	endproperty
	a_swrst_clear: assert property (p_swrst_clear) else $error("software reset not clearing");

	property p_clr_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		(q.clr_cnt == 10'h002) && !swrst ##1 !swrst |=> (q.flags == '0) && (q.clr_cnt == 10'h000);
	endproperty
	a_clr_hold: assert property (p_clr_hold) else $error("clear window wrong length");

	property p_w1c;
		@(posedge sys_clk) disable iff (!rst_n)
		q.flags[ST_OTEMP] && w1c[ST_OTEMP] && !live[ST_OTEMP] |=> !q.flags[ST_OTEMP];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

	property p_set_wins;
		@(posedge sys_clk) disable iff (!rst_n)
		live[ST_HSMAX] && (q.clr_cnt == 10'h000) && !swrst |=> q.flags[ST_HSMAX];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("live condition lost from flag");

	property p_masked;
		@(posedge sys_clk) disable iff (!rst_n)
		(q.mask[ST_ALARM_W-1:0] == 12'hFFF) |=> alarm_oe_b;
	endproperty
	a_masked: assert property (p_masked) else $error("masked condition drove alarm");

	property p_release;
		@(posedge sys_clk) disable iff (!rst_n)
		(live == '0) && (q.latch == 4'h0) |=> alarm_oe_b;
	endproperty
	a_release: assert property (p_release) else $error("alarm held with no cause");

	property p_latch_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		q.latch[0] && !q.mask[0] && !w1c[0] && !swrst && (act_out != FASU_ACT_OFF)
		|=> !alarm_oe_b ##1 q.latch[0] || $past(w1c[0]) || $past(swrst)
		|| $past(act_out == FASU_ACT_OFF);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched alarm released early");

	property p_code_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		fallback_apply && !swrst |=> fallback_apply;
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("fallback code dropped");

	property p_prio;
		@(posedge sys_clk) disable iff (!rst_n)
		live[ST_OTEMP] && (act_ot == FASU_ACT_CODE) && !swrst |=> fallback_apply;
	endproperty
	a_prio: assert property (p_prio) else $error("temperature action not taken");

	property p_off;
		@(posedge sys_clk) disable iff (!rst_n)
		q_open[1] && (act_out == FASU_ACT_OFF) && !swrst |=> chan_off[1] && !q.latch[1];
	endproperty
	a_off: assert property (p_off) else $error("channel not shut off on fault");

	property p_ot_alarm;
		@(posedge sys_clk) disable iff (!rst_n)
		live[ST_OTEMP] && !q.mask[ST_OTEMP] |=> !alarm_oe_b;
	endproperty
	a_ot_alarm: assert property (p_ot_alarm) else $error("no temperature alarm");

	property p_crc_flag;
		@(posedge sys_clk) disable iff (!rst_n)
		cfg.crc_en && crc_error && (q.clr_cnt == 10'h000) && !swrst |=> q.flags[ST_CRC];
	endproperty
	a_crc_flag: assert property (p_crc_flag) else $error("frame error flag missing");

	property p_wdt_flag;
		@(posedge sys_clk) disable iff (!rst_n)
		cfg.wdt_en && wdt_timeout && (q.clr_cnt == 10'h000) && !swrst |=> q.flags[ST_WDT];
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag missing");

	property p_act_step;
		@(posedge sys_clk) disable iff (!rst_n)
		(act_sel == FASU_ACT_CODE) && !swrst |=> fallback_apply;
	endproperty
	a_act_step: assert property (p_act_step) else $error("fallback code not applied");

	property p_rd_status;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && (reg_addr == OFS_STATUS) |=> reg_rvalid && (reg_rdata == {$past(pg), $past(q.flags)});
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status read wrong");

endmodule // fasu_top

// ### fasu_host.sv
module fasu_host
	import fasu_pkg::*;
(
	// Clock.
	input wire logic sys_clk,
	// Register port.
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// Released lines show the inverse of the last value.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		int n;
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(negedge sys_clk);
			n++;
		end
		d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
	endtask
endmodule // fasu_host

// ### tb_fault_alarm_status_unit.sv
module tb_fault_alarm_status_unit
	import fasu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] QC = 16'h0008;
	logic sys_clk, rst_b, wdt_timeout, crc_error, reg_wr, reg_rd, reg_rvalid;
	logic alarm_i, alarm_o, alarm_oe_b, fallback_apply;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [5:0] fallback_code;
	logic [3:0] chan_off;
	fasu_pins_t pins;
	fasu_cfg_t cfg;
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;
	// The alarm line has a pull-up.
	assign alarm_i = alarm_oe_b ? 1'b1 : alarm_o;
	fasu_top #(.QUAL_CYC(QC)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .pins(pins), .cfg(cfg),
		.wdt_timeout(wdt_timeout), .crc_error(crc_error), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .alarm_i(alarm_i), .alarm_o(alarm_o), .alarm_oe_b(alarm_oe_b),
		.fallback_code(fallback_code), .fallback_apply(fallback_apply), .chan_off(chan_off));
	fasu_host i_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cyc_wait(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] d;
		i_host.rd(a, d);
		chk(d & m, e);
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic t_regs;
		rchk(OFS_MASK, 16'hFFFF, MASK_RST);
		rchk(OFS_ACTION, 16'hFFFF, ACTION_RST);
		rchk(OFS_CODE, 16'hFFFF, {10'h000, CODE_RST});
		rchk(OFS_STATUS, 16'h0FFF, 16'h0000);
		rchk(8'h20, 16'hFFFF, 16'h0000);
		chk({10'h000, fallback_apply, alarm_oe_b, chan_off}, 16'h0010);
	endtask
	task automatic t_otemp;
		i_host.wr(OFS_CODE, 16'hFFEA);
		rchk(OFS_CODE, 16'hFFFF, 16'h002A);
		i_host.wr(OFS_ACTION, 16'h0001);
		pins.over_temp = 1'b1;
		cyc_wait(4);
		chk(16'(alarm_oe_b), 16'h0000);
		chk({9'h000, fallback_apply, fallback_code}, 16'h006A);
		i_host.wr(OFS_STATUS, 16'h0100);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0100);
		pins.over_temp = 1'b0;
		cyc_wait(4);
		chk(16'(alarm_oe_b), 16'h0001);
		chk({9'h000, fallback_apply, fallback_code}, 16'h006A);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0100);
		i_host.wr(OFS_STATUS, 16'h0100);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0000);
	endtask
	task automatic t_mask;
		i_host.wr(OFS_MASK, 16'h0100);
		pins.over_temp = 1'b1;
		cyc_wait(4);
		chk(16'(alarm_oe_b), 16'h0001);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0100);
		pins.over_temp = 1'b0;
		i_host.wr(OFS_MASK, 16'h0000);
		i_host.wr(OFS_STATUS, 16'h0FFF);
	endtask
	task automatic t_latch;
		cfg.bb_powered = 4'h1;
		cfg.iout_en = 4'h1;
		pins.iout_open = 4'h1;
		cyc_wait(6);
		chk(16'(alarm_oe_b), 16'h0001);
		cyc_wait(8);
		chk(16'(alarm_oe_b), 16'h0000);
		pins.iout_open = 4'h0;
		cyc_wait(6);
		chk(16'(alarm_oe_b), 16'h0000);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0001);
		i_host.wr(OFS_STATUS, 16'h0001);
		cyc_wait(2);
		chk(16'(alarm_oe_b), 16'h0001);
	endtask
	task automatic t_off;
		i_host.wr(OFS_ACTION, 16'h0008);
		cfg.bb_powered = 4'h2;
		cfg.iout_en = 4'h2;
		pins.iout_open = 4'h2;
		cyc_wait(14);
		chk(16'(chan_off), 16'h0002);
		pins.iout_open = 4'h0;
		cyc_wait(6);
		chk(16'(alarm_oe_b), 16'h0001);
		i_host.wr(OFS_STATUS, 16'h0002);
		cyc_wait(2);
		chk(16'(chan_off), 16'h0000);
	endtask
	task automatic t_comm;
		cfg.crc_en = 1'b1;
		cfg.wdt_en = 1'b1;
		crc_error = 1'b1;
		wdt_timeout = 1'b1;
		cyc_wait(1);
		crc_error = 1'b0;
		wdt_timeout = 1'b0;
		cyc_wait(2);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0600);
	endtask
	task automatic t_levels;
		cfg.pos_arm_en = 4'hF;
		cfg.neg_arm_en = 4'h1;
		cfg.vout_en = 4'h8;
		cfg.iout_en = 4'h4;
		pins.pos_ok = 4'hF;
		pins.conv_at_max = 4'h4;
		pins.vout_short = 4'h8;
		pins.iout_compl = 4'h4;
		cyc_wait(14);
		rchk(OFS_STATUS, 16'hF8FF, 16'hE884);
		pins.conv_at_max = 4'h0;
		pins.vout_short = 4'h0;
		pins.iout_compl = 4'h0;
	endtask
	task automatic t_swrst;
		i_host.wr(OFS_MASK, 16'h00FF);
		i_host.wr(OFS_SWRST, 16'h0000);
		pins.over_temp = 1'b1;
		cyc_wait(2);
		chk({9'h000, fallback_apply, fallback_code}, 16'h0000);
		rchk(OFS_MASK, 16'hFFFF, MASK_RST);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0000);
		cyc_wait(990);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0000);
		cyc_wait(30);
		rchk(OFS_STATUS, 16'h0FFF, 16'h0100);
		pins.over_temp = 1'b0;
	endtask
	task automatic t_prio;
		i_host.wr(OFS_ACTION, 16'h0044);
		cfg.iout_en = 4'h1;
		pins.iout_compl = 4'h1;
		pins.over_temp = 1'b1;
		cyc_wait(14);
		rchk(OFS_STATUS, 16'h0001, 16'h0000);
		pins.conv_sat = 4'h1;
		cyc_wait(14);
		rchk(OFS_STATUS, 16'h0001, 16'h0001);
		chk(16'(fallback_apply), 16'h0000);
		pins.over_temp = 1'b0;
		cyc_wait(4);
		chk(16'(fallback_apply), 16'h0001);
	endtask
	initial begin
		rst_b = 1'b0;
		pins = '0;
		cfg = '0;
		wdt_timeout = 1'b0;
		crc_error = 1'b0;
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		cyc_wait(1010);
		t_regs();
		t_otemp();
		t_mask();
		t_latch();
		t_off();
		t_comm();
		t_levels();
		t_swrst();
		t_prio();
		wrap_up();
	end
endmodule // tb_fault_alarm_status_unit
